// ===== design/rcr_map.vh
`ifndef RCR_MAP_VH
`define RCR_MAP_VH

// Register offsets
`define RCR_ADDR_THR_LOW     7'h19
`define RCR_ADDR_THR_HIGH    7'h1A
`define RCR_ADDR_WAKE_EN     7'h1C
`define RCR_ADDR_WAKE_STAT   7'h1D
`define RCR_ADDR_ANALOG      7'h20
`define RCR_ADDR_CHANNEL     7'h21
`define RCR_ADDR_MID_FIRST   7'h3C
`define RCR_ADDR_MID_LAST    7'h3F

// Reset values
`define RCR_RST_THR_LOW      8'h08
`define RCR_RST_THR_HIGH     8'h38
`define RCR_RST_WAKE_EN      8'h00
`define RCR_RST_WAKE_STAT    8'h01
`define RCR_RST_ANALOG       8'h00
`define RCR_RST_CHANNEL      8'h00

// Field positions
`define RCR_BIT_WAKE         0
`define RCR_BIT_AGC_OVR      6
`define RCR_BIT_MID_EN       5
`define RCR_BIT_AMP_OE       2
`define RCR_BIT_AMP_INV      1
`define RCR_BIT_SOFT_RST     0
`define RCR_BIT_AN_SEL       7

// Writable masks (reserved bits stay zero)
`define RCR_MASK_THR         8'h7F
`define RCR_MASK_WAKE_EN     8'h01
`define RCR_MASK_ANALOG      8'h66
`define RCR_MASK_CHANNEL     8'hFF

// Channel mapping: value 1 is 2402 MHz, 1 MHz spacing
`define RCR_CHAN_BASE_MHZ    12'd2401
`define RCR_CHAN_MAX         7'd79

`endif

// ===== design/rcr_amp_pin.v
`timescale 1ns/1ps
// External amplifier control pin driver
module rcr_amp_pin (
	// Control
	input  wire i_clk,
	input  wire i_sys_rst,
	input  wire i_amp_output_enable,
	input  wire i_amp_invert,
	input  wire i_amp_active,
	// Pin
	output reg  o_ext_amp_control_pin,
	output reg  o_ext_amp_control_pin_oe
);

	// RL9 RL10 pin drive, polarity
	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_ext_amp_control_pin    <= 1'b0;
			o_ext_amp_control_pin_oe <= 1'b0;
		end else begin
			o_ext_amp_control_pin_oe <= i_amp_output_enable;
			o_ext_amp_control_pin    <= i_amp_output_enable & (i_amp_active ^ i_amp_invert);
		end
	end

endmodule // rcr_amp_pin

// ===== design/rcr_register_slice.v
`timescale 1ns/1ps
// Summary of operation
// RL1: Seven-bit high threshold in bits 6:0 sets matches needed for a one.
// RL2: Perfect reception counts 64 or 32; 0x38 allows eight bad chips.
// RL3: High and low thresholds together set one and zero decision levels.
// RL4: Host writes zeros to reserved bits.
// RL5: Wake interrupt raised on wakeup condition, gated by enable bit 0.
// RL6: Wake status bit 0 resets to one, cleared by reading it.
// RL7: Analog bit 6 hands AGC and RSSI control to override registers.
// RL8: Manufacturing ID readable only while analog bit 5 is set.
// RL9: Analog bit 2 enables the external amplifier control pin.
// RL10: Analog bit 1 selects pin polarity; one is active low.
// RL11: Host never changes amplifier enable and polarity in one write.
// RL12: Writing one to analog bit 0 resets all registers, then self-clears.
// RL13: Channel bit 7 selects A and N counters, else 7-bit channel field.
// RL14: Channel 1 maps to 2402 MHz, 79 to 2480 MHz, 1 MHz steps.
// RL15: Wake interrupt is status AND enable, drops cycle after clearing read.
// RL16: Reserved bits read back as zero.
`include "rcr_map.vh"
module rcr_register_slice #(
	parameter THR_W  = 7,
	parameter CHIP_W = 7,
	parameter MID_W  = 32
) (
	// Clock and reset
	input  wire              i_clk,
	input  wire              i_sys_rst,
	// Register port
	input  wire [6:0]        i_reg_addr,
	input  wire              i_reg_wr,
	input  wire [7:0]        i_reg_wdata,
	input  wire              i_reg_rd,
	output reg  [7:0]        o_reg_rdata,
	// Correlator
	input  wire [CHIP_W-1:0] i_corr_match_count,
	input  wire              i_corr_count_valid,
	output reg               o_corr_bit_valid,
	output reg               o_corr_bit,
	output wire [THR_W-1:0]  o_thr_high,
	output wire [THR_W-1:0]  o_thr_low,
	// Wake
	input  wire              i_wake_event,
	output wire              o_wake_irq,
	// Analog controls
	output wire              o_agc_override,
	output wire              o_mid_power_en,
	input  wire [MID_W-1:0]  i_mid_value,
	input  wire              i_amp_active,
	output wire              o_ext_amp_control_pin,
	output wire              o_ext_amp_control_pin_oe,
	output wire              o_soft_reset,
	// Synthesizer source
	output wire              o_synth_use_an,
	output wire [6:0]        o_channel,
	output wire [11:0]       o_channel_mhz
);

	reg [7:0] thr_low_r;
	reg [7:0] thr_high_r;
	reg [7:0] wake_en_r;
	reg [7:0] wake_stat_r;
	reg [7:0] analog_r;
	reg [7:0] channel_r;
	reg       soft_rst_r;
	reg [7:0] rdata_nxt;
	wire      wr_analog;
	wire      rd_wake;

	assign wr_analog = i_reg_wr && (i_reg_addr == `RCR_ADDR_ANALOG);
	assign rd_wake   = i_reg_rd && (i_reg_addr == `RCR_ADDR_WAKE_STAT);

	// RL12 self-clearing reset pulse
	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= wr_analog & i_reg_wdata[`RCR_BIT_SOFT_RST];
		end
	end
	assign o_soft_reset = soft_rst_r;

	// Writable registers, reserved bits masked
	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			thr_low_r  <= `RCR_RST_THR_LOW;
			thr_high_r <= `RCR_RST_THR_HIGH;
			wake_en_r  <= `RCR_RST_WAKE_EN;
			analog_r   <= `RCR_RST_ANALOG;
			channel_r  <= `RCR_RST_CHANNEL;
		end else if (soft_rst_r) begin
			// RL12 restore defaults
			thr_low_r  <= `RCR_RST_THR_LOW;
			thr_high_r <= `RCR_RST_THR_HIGH;
			wake_en_r  <= `RCR_RST_WAKE_EN;
			analog_r   <= `RCR_RST_ANALOG;
			channel_r  <= `RCR_RST_CHANNEL;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`RCR_ADDR_THR_LOW: begin
					thr_low_r <= i_reg_wdata & `RCR_MASK_THR;
				end
				// RL1 high threshold store
				`RCR_ADDR_THR_HIGH: begin
					thr_high_r <= i_reg_wdata & `RCR_MASK_THR;
				end
				// RL16 reserved masked
				`RCR_ADDR_WAKE_EN: begin
					wake_en_r <= i_reg_wdata & `RCR_MASK_WAKE_EN;
				end
				`RCR_ADDR_ANALOG: begin
					analog_r <= i_reg_wdata & `RCR_MASK_ANALOG;
				end
				// RL13 channel register
				`RCR_ADDR_CHANNEL: begin
					channel_r <= i_reg_wdata & `RCR_MASK_CHANNEL;
				end
				default: begin
					thr_low_r <= thr_low_r;
				end
			endcase
		end
	end

	// RL6 wake status, set wins over read-clear
	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wake_stat_r <= `RCR_RST_WAKE_STAT;
		end else if (soft_rst_r) begin
			wake_stat_r <= `RCR_RST_WAKE_STAT;
		end else if (i_wake_event) begin
			wake_stat_r <= `RCR_RST_WAKE_STAT;
		end else if (rd_wake) begin
			wake_stat_r <= 8'h00;
		end
	end

	// RL5 RL15 gated wake interrupt
	assign o_wake_irq = wake_stat_r[`RCR_BIT_WAKE] & wake_en_r[`RCR_BIT_WAKE];

	// Read mux
	always @* begin
		rdata_nxt = 8'h00;
		case (i_reg_addr)
			`RCR_ADDR_THR_LOW:   rdata_nxt = thr_low_r;
			`RCR_ADDR_THR_HIGH:  rdata_nxt = thr_high_r;
			`RCR_ADDR_WAKE_EN:   rdata_nxt = wake_en_r;
			`RCR_ADDR_WAKE_STAT: rdata_nxt = wake_stat_r;
			`RCR_ADDR_ANALOG:    rdata_nxt = analog_r;
			`RCR_ADDR_CHANNEL:   rdata_nxt = channel_r;
			default: begin
				// RL8 gated ID read
				if (analog_r[`RCR_BIT_MID_EN] && i_reg_addr >= `RCR_ADDR_MID_FIRST
					&& i_reg_addr <= `RCR_ADDR_MID_LAST) begin
					rdata_nxt = i_mid_value[{i_reg_addr[1:0], 3'b000} +: 8];
				end
			end
		endcase
	end

	// Registered read data
	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_reg_rdata <= 8'h00;
		end else if (i_reg_rd) begin
			o_reg_rdata <= rdata_nxt;
		end
	end

	// RL3 RL2 correlator decision
	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_corr_bit_valid <= 1'b0;
			o_corr_bit       <= 1'b0;
		end else begin
			o_corr_bit_valid <= 1'b0;
			if (i_corr_count_valid) begin
				if (i_corr_match_count >= thr_high_r[CHIP_W-1:0]) begin
					o_corr_bit_valid <= 1'b1;
					o_corr_bit       <= 1'b1;
				end else if (i_corr_match_count <= thr_low_r[CHIP_W-1:0]) begin
					o_corr_bit_valid <= 1'b1;
					o_corr_bit       <= 1'b0;
				end
			end
		end
	end

	assign o_thr_high = thr_high_r[THR_W-1:0];
	assign o_thr_low  = thr_low_r[THR_W-1:0];

	// RL7 AGC override
	assign o_agc_override = analog_r[`RCR_BIT_AGC_OVR];
	assign o_mid_power_en = analog_r[`RCR_BIT_MID_EN];

	// RL13 RL14 synthesizer source
	assign o_synth_use_an = channel_r[`RCR_BIT_AN_SEL];
	assign o_channel      = channel_r[6:0];
	assign o_channel_mhz  = channel_r[`RCR_BIT_AN_SEL] ? 12'h000 : (`RCR_CHAN_BASE_MHZ + {5'b00000, channel_r[6:0]});

	// RL9 RL10 amplifier pin
	rcr_amp_pin u_amp (
		.i_clk                    (i_clk),
		.i_sys_rst                (i_sys_rst),
		.i_amp_output_enable      (analog_r[`RCR_BIT_AMP_OE]),
		.i_amp_invert             (analog_r[`RCR_BIT_AMP_INV]),
		.i_amp_active             (i_amp_active),
		.o_ext_amp_control_pin    (o_ext_amp_control_pin),
		.o_ext_amp_control_pin_oe (o_ext_amp_control_pin_oe)
	);

endmodule // rcr_register_slice

// ===== testbench/rcr_chk.sv
`timescale 1ns/1ps
module rcr_chk #(parameter THR_W = 7) (
	// Clock, reset and strobes
	input wire             i_clk, i_sys_rst, i_reg_wr, i_reg_rd, i_wake_event, i_amp_active,
	// Buses
	input wire [6:0]       i_reg_addr, o_channel,
	input wire [7:0]       i_reg_wdata, o_reg_rdata,
	input wire [THR_W-1:0] o_thr_high,
	// Outputs watched
	input wire             o_wake_irq, o_agc_override, o_mid_power_en, o_soft_reset, o_synth_use_an,
	input wire             o_ext_amp_control_pin, o_ext_amp_control_pin_oe
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// Analog control writes, without and with the reset bit
	sequence s_anw; i_reg_wr && i_reg_addr == 7'h20 && !i_reg_wdata[0] && !o_soft_reset; endsequence
	sequence s_srw; i_reg_wr && i_reg_addr == 7'h20 && i_reg_wdata[0]; endsequence
	// Pin driver samples the register one edge after it is written
	property p_oe; s_anw |=> ##1 o_ext_amp_control_pin_oe == $past(i_reg_wdata[2], 2); endproperty
	a_oe: assert property (p_oe) else $error("amp enable wrong");
	property p_pin; s_anw ##1 !i_reg_wr |=> ##1 o_ext_amp_control_pin ==
		($past(i_reg_wdata[2], 3) & ($past(i_amp_active) ^ $past(i_reg_wdata[1], 3))); endproperty
	a_pin: assert property (p_pin) else $error("amp pin level wrong");
	property p_srst; s_srw |=> o_soft_reset ##1 !o_soft_reset && !o_agc_override && o_thr_high == 7'h38; endproperty
	a_srst: assert property (p_srst) else $error("soft reset wrong");
	property p_agc; s_anw |=> {o_agc_override, o_mid_power_en} == $past(i_reg_wdata[6:5]); endproperty
	a_agc: assert property (p_agc) else $error("agc or id enable wrong");
	property p_irq; i_reg_rd && i_reg_addr == 7'h1d && !i_wake_event && !o_soft_reset |=> !o_wake_irq; endproperty
	a_irq: assert property (p_irq) else $error("wake irq not cleared");
	property p_mid; i_reg_rd && i_reg_addr[6:2] == 5'h0f && !o_mid_power_en |=> o_reg_rdata == 8'h00; endproperty
	a_mid: assert property (p_mid) else $error("id readable while gated");
	property p_chan; i_reg_wr && i_reg_addr == 7'h21 && !o_soft_reset |=>
		{o_synth_use_an, o_channel} == $past(i_reg_wdata); endproperty
	a_chan: assert property (p_chan) else $error("channel fields wrong");
	property p_thr; i_reg_wr && i_reg_addr == 7'h1a && !o_soft_reset |=>
		o_thr_high == $past(i_reg_wdata[6:0]); endproperty
	a_thr: assert property (p_thr) else $error("high threshold wrong");
endmodule // rcr_chk
bind rcr_register_slice rcr_chk #(.THR_W(THR_W)) u_chk (.*);

// ===== testbench/rcr_host.sv
`timescale 1ns/1ps
module rcr_host (
	// Clock and read data
	input  wire       i_clk,
	input  wire [7:0] i_rdata,
	// Register strobes
	output reg  [6:0] o_addr,
	output reg        o_wr,
	output reg  [7:0] o_wdata,
	output reg        o_rd
);
	initial {o_addr, o_wr, o_wdata, o_rd} = 17'h0_0000;
	task w(input [6:0] a, input [7:0] d);
	begin
		@(negedge i_clk) {o_addr, o_wr, o_wdata} = {a, 1'b1, d};
		@(negedge i_clk) o_wr = 1'b0;
	end
	endtask
	// One-cycle read strobe, data after the edge
	task r(input [6:0] a, output [7:0] d);
	begin
		@(negedge i_clk) {o_addr, o_rd} = {a, 1'b1};
		@(negedge i_clk) o_rd = 1'b0;
		d = i_rdata;
	end
	endtask
endmodule // rcr_host

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
	reg         clk = 1'b0, rst = 1'b1, ev = 1'b0, act = 1'b1, cv = 1'b0;
	reg  [6:0]  cnt = 7'h00;
	reg  [7:0]  d;
	wire [6:0]  addr;
	wire [7:0]  wd, rdat;
	wire        wr, rd, bv, b1, irq, agc, pin, oe, srst, an;
	wire [11:0] mhz;
	integer     n_mismatch = 0, n_compared = 0;
	// Clock
	initial forever #4 clk = ~clk;
	rcr_host host (.i_clk(clk), .i_rdata(rdat), .o_addr(addr), .o_wr(wr), .o_wdata(wd), .o_rd(rd));
	rcr_register_slice uut (.i_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
		.i_reg_wdata(wd), .i_reg_rd(rd), .o_reg_rdata(rdat), .i_corr_match_count(cnt),
		.i_corr_count_valid(cv), .o_corr_bit_valid(bv), .o_corr_bit(b1), .o_thr_high(), .o_thr_low(),
		.i_wake_event(ev), .o_wake_irq(irq), .o_agc_override(agc), .o_mid_power_en(),
		.i_mid_value(32'h1234_5678), .i_amp_active(act), .o_ext_amp_control_pin(pin),
		.o_ext_amp_control_pin_oe(oe), .o_soft_reset(srst), .o_synth_use_an(an), .o_channel(),
		.o_channel_mhz(mhz));
	task chk(input [11:0] s, input [11:0] e);
	begin
		n_compared = n_compared + 1;
		if (s !== e) begin
			n_mismatch = n_mismatch + 1;
			$display("unexpected at %0t: %h vs %h", $time, s, e);
		end
	end
	endtask
	task rc(input [6:0] a, input [7:0] e);
	begin
		host.r(a, d);
		chk(d, e);
	end
	endtask
	task corr(input [6:0] c, input [11:0] v, input [11:0] b);
	begin
		@(negedge clk) {cv, cnt} = {1'b1, c};
		@(negedge clk) cv = 1'b0;
		chk({bv, b1 & bv}, {v[0], b[0]});
	end
	endtask
	task pulse;
	begin
		@(negedge clk) ev = 1'b1;
		@(negedge clk) ev = 1'b0;
	end
	endtask
	task end_sim;
	begin
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	end
	endtask
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		rc(7'h1a, 8'h38);
		rc(7'h19, 8'h08);
		rc(7'h1d, 8'h01);
		rc(7'h1d, 8'h00);
		rc(7'h7f, 8'h00);
		corr(7'h38, 12'h001, 12'h001);
		corr(7'h37, 12'h000, 12'h000);
		corr(7'h08, 12'h001, 12'h000);
		host.w(7'h1a, 8'h20);
		corr(7'h20, 12'h001, 12'h001);
		host.w(7'h1c, 8'h01);
		pulse;
		chk(irq, 12'h001);
		rc(7'h1d, 8'h01);
		chk(irq, 12'h000);
		host.w(7'h1c, 8'h00);
		pulse;
		chk(irq, 12'h000);
		host.w(7'h20, 8'h04);
		@(negedge clk);
		chk({oe, pin}, 12'h003);
		host.w(7'h20, 8'h06);
		@(negedge clk);
		chk(pin, 12'h000);
		act = 1'b0;
		@(negedge clk);
		chk(pin, 12'h001);
		host.w(7'h20, 8'h02);
		@(negedge clk);
		chk(oe, 12'h000);
		rc(7'h3c, 8'h00);
		host.w(7'h20, 8'h60);
		rc(7'h3f, 8'h12);
		chk(agc, 12'h001);
		host.w(7'h21, 8'h01);
		chk(mhz, 12'h962);
		host.w(7'h21, 8'h02);
		chk(mhz, 12'h963);
		host.w(7'h21, 8'hcf);
		chk(an, 12'h001);
		chk(mhz, 12'h000);
		host.w(7'h20, 8'h41);
		chk(srst, 12'h001);
		@(negedge clk);
		chk({srst, agc}, 12'h000);
		rc(7'h1a, 8'h38);
		rc(7'h21, 8'h00);
		rc(7'h20, 8'h00);
		end_sim;
	end
endmodule // tb
